// ==== hw/two_entry_buf.sv ====
// two_entry_buf: two-word buffer with valid/ready on both sides.
// assumes: one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module two_entry_buf #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

endmodule // two_entry_buf
`default_nettype wire

// ==== hw/tx_host_pkg.sv ====
// tx_host_pkg: sizes, management map, reset values and states of the
// transmitter host-port logic.
// assumes: included before every other file of the block.
package tx_host_pkg;

  // link shape, fixed at build time
  localparam int LANES = 2;
  localparam int CONVERTERS = 4;
  localparam int SAMPLES = 1;
  localparam int WIDTH_MULT = 2;
  localparam int RESOLUTION = 16;
  localparam int CTRL_PER_SAMPLE = 2;
  localparam int OCTET_W = 8;
  localparam int SAMPLE_W = CONVERTERS * SAMPLES * WIDTH_MULT * RESOLUTION;
  localparam int SAMPLE_MIN_W = CONVERTERS * SAMPLES * RESOLUTION;
  localparam int CTRL_W = CONVERTERS * SAMPLES * WIDTH_MULT * CTRL_PER_SAMPLE;
  localparam int LANE_W = SAMPLE_W / LANES;
  localparam int LANE_CTRL_W = CTRL_W / LANES;
  localparam int BUF_W = SAMPLE_W + CTRL_W;

  // management port
  localparam int MGMT_ADDR_W = 10;
  localparam int MGMT_DATA_W = 32;
  localparam int WORD_LSB = 2;
  localparam int WORD_IDX_W = MGMT_ADDR_W - WORD_LSB;
  localparam logic [MGMT_ADDR_W-1:0] OFS_CONTROL = 10'h000;
  localparam logic [MGMT_ADDR_W-1:0] OFS_STATUS = 10'h004;
  localparam logic [MGMT_ADDR_W-1:0] OFS_WORD_COUNT = 10'h008;
  localparam logic [MGMT_ADDR_W-1:0] OFS_SCRATCH = 10'h00C;
  localparam logic [MGMT_DATA_W-1:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [MGMT_DATA_W-1:0] SCRATCH_RESET = 32'h0000_0000;
  localparam logic [MGMT_DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam int CTRL_STREAM_EN_BIT = 0;
  localparam int STAT_TX_READY_LSB = 0;
  localparam int STAT_AFE_READY_LSB = 8;
  localparam int STAT_BUF_FULL_BIT = 16;

  // transceiver reconfiguration port
  localparam int CFG_OFS_W = 19;
  localparam int CFG_LANE_W = (LANES > 1) ? $clog2(LANES) : 0;
  localparam int CFG_ADDR_W = CFG_LANE_W + CFG_OFS_W;
  localparam int CFG_DATA_W = 8;

  typedef enum logic [1:0] {
    CFG_IDLE,
    CFG_BUSY,
    CFG_DONE
  } cfg_state_t;

endpackage

// ==== hw/tx_link_host_ports.sv ====
// tx_link_host_ports: host-facing ports of a serial converter-link transmitter:
// management slave, shared transceiver reconfiguration port, sample input.
// assumes: the transceiver and transport sides run on sys_clk; ready pins
// from the transceiver are asynchronous and are synchronised here.
// Function
// (RULE1) ignore bus unless select with strobe
// (RULE2) masters without select tie it high
// (RULE3) 10-bit byte address, four bytes per word
// (RULE4) write and read data 32 bits
// (RULE5) read strobe returns addressed word
// (RULE6) write strobe carries data same cycle
// (RULE7) management stall held at zero
// (RULE8) reconfig address: lane bits above 19-bit offset
// (RULE9) single lane gives exactly 19 address bits
// (RULE10) one shared reconfig port, 8-bit data
// (RULE11) sample width M*S*WM*N, at least M*S*N
// (RULE12) big endian, first octet in top byte
// (RULE13) lane 0 in most significant slice
// (RULE14) control bits input sized M*S*WM*CS
// (RULE15) per-lane transceiver and front-end ready outputs
// (RULE16) management domain crossing made safe
// (RULE17) management has its own async reset; here rstn is shared with the whole block
// (RULE18) write updates same edge, read harmless
`timescale 1ns/1ps
`default_nettype none
module tx_link_host_ports
  import tx_host_pkg::*;
(
  // clock and management reset
  input wire logic sys_clk,
  input wire logic rstn,
  // management slave
  input wire logic mgmt_select,
  input wire logic [MGMT_ADDR_W-1:0] mgmt_byte_offset,
  input wire logic [MGMT_DATA_W-1:0] mgmt_wdata,
  input wire logic mgmt_rd_strobe,
  input wire logic mgmt_wr_strobe,
  output logic [MGMT_DATA_W-1:0] mgmt_rdata,
  output logic mgmt_rdata_valid,
  output logic mgmt_stall,
  // shared reconfiguration port, host side
  input wire logic xcvr_cfg_rd,
  input wire logic xcvr_cfg_wr,
  input wire logic [CFG_ADDR_W-1:0] xcvr_cfg_addr,
  input wire logic [CFG_DATA_W-1:0] xcvr_cfg_wdata,
  output logic [CFG_DATA_W-1:0] xcvr_cfg_rdata,
  output logic xcvr_cfg_stall,
  // reconfiguration port, transceiver side
  output logic phy_cfg_req,
  output logic phy_cfg_we,
  output logic [CFG_LANE_W-1:0] phy_cfg_lane,
  output logic [CFG_OFS_W-1:0] phy_cfg_offset,
  output logic [CFG_DATA_W-1:0] phy_cfg_wdata,
  input wire logic [CFG_DATA_W-1:0] phy_cfg_rdata,
  input wire logic phy_cfg_ack,
  // sample input
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [SAMPLE_W-1:0] sample_word_in,
  input wire logic [CTRL_W-1:0] sample_ctrl_bits_in,
  // transport side, lane l at slice l
  output logic tl_valid,
  input wire logic tl_ready,
  output logic [SAMPLE_W-1:0] tl_lane_data,
  output logic [CTRL_W-1:0] tl_lane_ctrl,
  // lane readiness
  input wire logic [LANES-1:0] phy_tx_ready_pin,
  input wire logic [LANES-1:0] phy_afe_ready_pin,
  output logic [LANES-1:0] lane_tx_ready,
  output logic [LANES-1:0] lane_afe_ready
);

  // management access decode
  logic bus_wr;
  logic bus_rd;
  logic [MGMT_ADDR_W-1:0] word_addr;
  logic [MGMT_DATA_W-1:0] control_reg;
  logic [MGMT_DATA_W-1:0] scratch_reg;
  logic [MGMT_DATA_W-1:0] word_count_reg;
  logic [MGMT_DATA_W-1:0] status_word;
  logic [MGMT_DATA_W-1:0] read_mux;
  logic stream_en;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [BUF_W-1:0] buf_out;

  // sub-word address bits are dropped: every access is one aligned word
  assign word_addr = {mgmt_byte_offset[MGMT_ADDR_W-1:WORD_LSB], {WORD_LSB{1'b0}}}; // see (RULE3)
  assign bus_wr = mgmt_select && mgmt_wr_strobe; // see (RULE1)
  assign bus_rd = mgmt_select && mgmt_rd_strobe && !mgmt_wr_strobe; // see (RULE1)
  assign mgmt_stall = 1'b0; // see (RULE7)
  assign stream_en = control_reg[CTRL_STREAM_EN_BIT];

  always_ff @(posedge sys_clk or negedge rstn) begin // see (RULE17)
    if (!rstn) begin
      control_reg <= CONTROL_RESET;
      scratch_reg <= SCRATCH_RESET;
    end else if (bus_wr) begin // see (RULE18) (RULE6)
      if (word_addr == OFS_CONTROL) begin
        control_reg <= mgmt_wdata; // see (RULE4)
      end
      if (word_addr == OFS_SCRATCH) begin
        scratch_reg <= mgmt_wdata;
      end
    end
  end

  always_comb begin
    status_word = ZERO_WORD;
    status_word[STAT_TX_READY_LSB +: LANES] = lane_tx_ready;
    status_word[STAT_AFE_READY_LSB +: LANES] = lane_afe_ready;
    status_word[STAT_BUF_FULL_BIT] = !buf_in_ready;
  end

  always_comb begin
    case (word_addr)
      OFS_CONTROL: read_mux = control_reg;
      OFS_STATUS: read_mux = status_word;
      OFS_WORD_COUNT: read_mux = word_count_reg;
      OFS_SCRATCH: read_mux = scratch_reg;
      default: read_mux = ZERO_WORD;
    endcase
  end

  // read data is registered; the master samples it one edge after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mgmt_rdata <= ZERO_WORD;
      mgmt_rdata_valid <= 1'b0;
    end else begin
      mgmt_rdata_valid <= bus_rd;
      if (bus_rd) begin
        mgmt_rdata <= read_mux; // see (RULE5) (RULE18)
      end
    end
  end

  // lane readiness pins cross into this domain through two flops
  logic [LANES-1:0] txr_meta_reg;
  logic [LANES-1:0] afe_meta_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txr_meta_reg <= '0;
      afe_meta_reg <= '0;
      lane_tx_ready <= '0;
      lane_afe_ready <= '0;
    end else begin
      txr_meta_reg <= phy_tx_ready_pin; // see (RULE16)
      afe_meta_reg <= phy_afe_ready_pin;
      lane_tx_ready <= txr_meta_reg; // see (RULE15)
      lane_afe_ready <= afe_meta_reg;
    end
  end

  // reconfiguration: one port for both directions, held until the phy acks
  cfg_state_t cfg_state_reg;
  logic cfg_host_req;

  assign cfg_host_req = xcvr_cfg_rd || xcvr_cfg_wr;
  assign xcvr_cfg_stall = cfg_host_req && (cfg_state_reg != CFG_DONE); // see (RULE10)
  assign phy_cfg_req = (cfg_state_reg == CFG_BUSY);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_state_reg <= CFG_IDLE;
    end else begin
      case (cfg_state_reg)
        CFG_IDLE: begin
          if (cfg_host_req) begin
            cfg_state_reg <= CFG_BUSY;
          end
        end
        CFG_BUSY: begin
          if (phy_cfg_ack) begin
            cfg_state_reg <= CFG_DONE;
          end
        end
        CFG_DONE: cfg_state_reg <= CFG_IDLE;
        default: cfg_state_reg <= CFG_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phy_cfg_we <= 1'b0;
      phy_cfg_lane <= '0;
      phy_cfg_offset <= '0;
      phy_cfg_wdata <= '0;
    end else if (cfg_state_reg == CFG_IDLE && cfg_host_req) begin
      phy_cfg_we <= xcvr_cfg_wr;
      phy_cfg_lane <= xcvr_cfg_addr[CFG_ADDR_W-1:CFG_OFS_W]; // see (RULE8) (RULE9)
      phy_cfg_offset <= xcvr_cfg_addr[CFG_OFS_W-1:0];
      phy_cfg_wdata <= xcvr_cfg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      xcvr_cfg_rdata <= '0;
    end else if (cfg_state_reg == CFG_BUSY && phy_cfg_ack) begin
      xcvr_cfg_rdata <= phy_cfg_rdata;
    end
  end

  // sample path: data and control travel together through the buffer

  assign buf_in_valid = sample_valid && stream_en;
  assign sample_ready = buf_in_ready && stream_en;

  two_entry_buf #(
    .W(BUF_W)
  ) u_buf (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({sample_word_in, sample_ctrl_bits_in}), // see (RULE11) (RULE14)
    .out_valid(tl_valid),
    .out_ready(tl_ready),
    .out_data(buf_out)
  );

  // lane 0 sits in the top slice of the input word; lanes are renumbered
  // so the transport side indexes lane l at slice l
  genvar ln;
  generate
    for (ln = 0; ln < LANES; ln++) begin : g_lane
      assign tl_lane_data[ln*LANE_W +: LANE_W] =
        buf_out[CTRL_W + (LANES-1-ln)*LANE_W +: LANE_W]; // see (RULE13) (RULE12)
      assign tl_lane_ctrl[ln*LANE_CTRL_W +: LANE_CTRL_W] =
        buf_out[(LANES-1-ln)*LANE_CTRL_W +: LANE_CTRL_W];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      word_count_reg <= ZERO_WORD;
    end else if (sample_valid && sample_ready) begin
      word_count_reg <= word_count_reg + 32'h0000_0001;
    end
  end

  property p_stall_zero; // see (RULE7)
    @(posedge sys_clk) disable iff (!rstn) (mgmt_select && (mgmt_rd_strobe || mgmt_wr_strobe)) |-> !mgmt_stall;
  endproperty
  a_stall_zero: assert property (p_stall_zero) else $error("management stall raised"); // see (RULE7)

  property p_write_lands; // see (RULE18)
    @(posedge sys_clk) disable iff (!rstn)
      (mgmt_select && mgmt_wr_strobe && mgmt_byte_offset == OFS_SCRATCH) |=> scratch_reg == $past(mgmt_wdata);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("scratch write lost"); // see (RULE18)

  property p_no_select_ignored; // see (RULE1)
    @(posedge sys_clk) disable iff (!rstn) (!mgmt_select) |=> $stable(control_reg) && $stable(scratch_reg);
  endproperty
  a_no_select_ignored: assert property (p_no_select_ignored) else $error("write without select"); // see (RULE1)

  property p_read_harmless; // see (RULE18)
    @(posedge sys_clk) disable iff (!rstn)
      (mgmt_select && mgmt_rd_strobe && !mgmt_wr_strobe) |=> $stable(control_reg) && $stable(scratch_reg);
  endproperty
  a_read_harmless: assert property (p_read_harmless) else $error("read altered a register"); // see (RULE18)

  property p_read_scratch; // see (RULE5)
    @(posedge sys_clk) disable iff (!rstn)
      (bus_rd && mgmt_byte_offset == OFS_SCRATCH) |=> mgmt_rdata_valid && mgmt_rdata == $past(scratch_reg);
  endproperty
  a_read_scratch: assert property (p_read_scratch) else $error("wrong scratch read data"); // see (RULE5)

  property p_read_control_mirror; // see (RULE3)
    @(posedge sys_clk) disable iff (!rstn)
      (bus_rd && mgmt_byte_offset[MGMT_ADDR_W-1:WORD_LSB] == '0) |=> mgmt_rdata == $past(control_reg);
  endproperty
  a_read_control_mirror: assert property (p_read_control_mirror) else $error("word decode wrong"); // see (RULE3)

  property p_ready_sync; // see (RULE15)
    @(posedge sys_clk) disable iff (!rstn) phy_tx_ready_pin[0] [*3] |-> lane_tx_ready[0];
  endproperty
  a_ready_sync: assert property (p_ready_sync) else $error("lane ready not followed"); // see (RULE15)

  property p_ready_delay; // see (RULE16)
    @(posedge sys_clk) disable iff (!rstn) $rose(lane_afe_ready[0]) |-> $past(phy_afe_ready_pin[0], 2);
  endproperty
  a_ready_delay: assert property (p_ready_delay) else $error("front-end ready crossed too early"); // see (RULE16)

  property p_cfg_stall; // see (RULE10)
    @(posedge sys_clk) disable iff (!rstn)
      (cfg_host_req && cfg_state_reg == CFG_IDLE) |-> xcvr_cfg_stall ##1 phy_cfg_req;
  endproperty
  a_cfg_stall: assert property (p_cfg_stall) else $error("reconfig request not held"); // see (RULE10)

  property p_lane_order; // see (RULE13)
    @(posedge sys_clk) disable iff (!rstn)
      (sample_valid && sample_ready && !tl_valid) |=> tl_valid
        && tl_lane_data[0 +: LANE_W] == $past(sample_word_in[SAMPLE_W-LANE_W +: LANE_W]);
  endproperty
  a_lane_order: assert property (p_lane_order) else $error("lane slice order wrong"); // see (RULE13)

  property p_top_octet; // see (RULE12)
    @(posedge sys_clk) disable iff (!rstn)
      (sample_valid && sample_ready && !tl_valid) |=>
        tl_lane_data[LANE_W-OCTET_W +: OCTET_W] == $past(sample_word_in[SAMPLE_W-OCTET_W +: OCTET_W]);
  endproperty
  a_top_octet: assert property (p_top_octet) else $error("first octet misplaced"); // see (RULE12)

  property p_gate_stream; // see (RULE11)
    @(posedge sys_clk) disable iff (!rstn) !control_reg[CTRL_STREAM_EN_BIT] |-> !sample_ready;
  endproperty
  a_gate_stream: assert property (p_gate_stream) else $error("sample accepted while disabled"); // see (RULE11)

endmodule // tx_link_host_ports
`default_nettype wire

// ==== sim/phy_cfg_model.sv ====
// phy_cfg_model: transceiver side of the reconfiguration port, one 8-bit word per lane.
// assumes: same clock as the block; req is held until ack, ack is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module phy_cfg_model
  import tx_host_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // answer speed
  input wire logic slow,
  // request from the block
  input wire logic req,
  input wire logic we,
  input wire logic [CFG_LANE_W-1:0] lane,
  input wire logic [CFG_OFS_W-1:0] offset,
  input wire logic [CFG_DATA_W-1:0] wdata,
  // answer
  output logic [CFG_DATA_W-1:0] rdata,
  output logic ack
);
  logic [3:0] cnt_reg;
  logic [CFG_DATA_W-1:0] mem_reg [LANES];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
      ack <= 1'b0;
      rdata <= 8'h00;
      mem_reg <= '{default: 8'h00};
    end else begin
      ack <= 1'b0;
      // rdata toggles outside a read answer cycle so a sample one cycle late reads inverted
      rdata <= ~rdata;
      if (req && !ack) begin
        if (cnt_reg == (slow ? 4'h5 : 4'h1)) begin
          cnt_reg <= 4'h0;
          ack <= 1'b1;
          if (we) begin
            mem_reg[lane] <= wdata;
          end else begin
            rdata <= mem_reg[lane];
          end
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule // phy_cfg_model
`default_nettype wire

// ==== sim/testbench.sv ====
// testbench: directed scenarios for the host ports, with the phy model on the far side.
// assumes: every side of the block runs on sys_clk at 10 MHz.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tx_host_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, sel = 1'b0, rd = 1'b0, wr = 1'b0, mrv, mstall;
  logic [MGMT_ADDR_W-1:0] addr = 10'h000;
  logic [MGMT_DATA_W-1:0] wdata = 32'h0000_0000, mrdata, got;
  logic crd = 1'b0, cwr = 1'b0, cstall, preq, pwe, pack, slow = 1'b0;
  logic [CFG_ADDR_W-1:0] caddr = 20'h0_0000;
  logic [CFG_DATA_W-1:0] cwdata = 8'h00, crdata, pwdata, prdata;
  logic [CFG_LANE_W-1:0] plane;
  logic [CFG_OFS_W-1:0] pofs;
  logic svalid = 1'b0, sready, tvalid, tready = 1'b0;
  logic [SAMPLE_W-1:0] sword = '0, tdata;
  logic [CTRL_W-1:0] sctrl = '0, tctrl;
  logic [LANES-1:0] txp = '0, afep = '0, txr, afer;
  int errors = 0, n_checks = 0, cycles = 0;
  tx_link_host_ports uut (.sys_clk(sys_clk), .rstn(rstn), .mgmt_select(sel), .mgmt_byte_offset(addr),
    .mgmt_wdata(wdata), .mgmt_rd_strobe(rd), .mgmt_wr_strobe(wr), .mgmt_rdata(mrdata),
    .mgmt_rdata_valid(mrv), .mgmt_stall(mstall), .xcvr_cfg_rd(crd), .xcvr_cfg_wr(cwr),
    .xcvr_cfg_addr(caddr), .xcvr_cfg_wdata(cwdata), .xcvr_cfg_rdata(crdata), .xcvr_cfg_stall(cstall),
    .phy_cfg_req(preq), .phy_cfg_we(pwe), .phy_cfg_lane(plane), .phy_cfg_offset(pofs),
    .phy_cfg_wdata(pwdata), .phy_cfg_rdata(prdata), .phy_cfg_ack(pack), .sample_valid(svalid),
    .sample_ready(sready), .sample_word_in(sword), .sample_ctrl_bits_in(sctrl), .tl_valid(tvalid),
    .tl_ready(tready), .tl_lane_data(tdata), .tl_lane_ctrl(tctrl), .phy_tx_ready_pin(txp),
    .phy_afe_ready_pin(afep), .lane_tx_ready(txr), .lane_afe_ready(afer));
  phy_cfg_model phy (.sys_clk(sys_clk), .rstn(rstn), .slow(slow), .req(preq), .we(pwe), .lane(plane),
    .offset(pofs), .wdata(pwdata), .rdata(prdata), .ack(pack));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] seen);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end
  // one access; a write drives its data in the strobe cycle
  task automatic mgmt_wr(input logic s, input logic [9:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    sel <= s; wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge sys_clk);
    sel <= 1'b0; wr <= 1'b0;
  endtask
  task automatic mgmt_rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    sel <= 1'b1; rd <= 1'b1; addr <= a;
    @(posedge sys_clk);
    sel <= 1'b0; rd <= 1'b0;
    #1;
    chk("rdata_valid", 1, mrv);
    chk("mgmt_stall", 0, mstall);
    d = mrdata;
    @(posedge sys_clk);
    #1 chk("rdata_valid_drop", 0, mrv);
  endtask
  task automatic cfg_access(input logic w, input logic [19:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    cwr <= w; crd <= !w; caddr <= a; cwdata <= d;
    repeat (40) begin
      @(negedge sys_clk);
      if (cstall === 1'b0) break;
    end
    chk("cfg_stall", 0, cstall);
    chk("cfg_lane", a[19], plane);
    chk("cfg_offset", a[18:0], pofs);
    q = crdata;
    @(posedge sys_clk);
    cwr <= 1'b0; crd <= 1'b0;
  endtask
  task automatic push(input logic [127:0] w, input logic [15:0] c);
    @(posedge sys_clk);
    svalid <= 1'b1; sword <= w; sctrl <= c;
    repeat (20) begin
      @(negedge sys_clk);
      if (sready === 1'b1) break;
    end
    @(posedge sys_clk);
    svalid <= 1'b0;
  endtask
  task automatic t_mgmt();
    mgmt_wr(1'b1, OFS_SCRATCH, 32'h1234_5678);
    mgmt_rd(OFS_SCRATCH, got);
    chk("scratch", 32'h1234_5678, got);
    mgmt_rd(10'h00F, got);
    chk("scratch_low_bits", 32'h1234_5678, got);
    mgmt_wr(1'b0, OFS_SCRATCH, 32'hDEAD_BEEF);
    mgmt_rd(OFS_SCRATCH, got);
    chk("scratch_unselected", 32'h1234_5678, got);
    mgmt_wr(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
    mgmt_rd(OFS_STATUS, got);
    chk("status_ro", 32'h0000_0000, got);
    mgmt_rd(10'h3FC, got);
    chk("unmapped", 32'h0000_0000, got);
  endtask
  task automatic t_cfg();
    logic [7:0] q;
    slow <= 1'b1;
    cfg_access(1'b1, 20'h0_1234, 8'h3C, q);
    slow <= 1'b0;
    cfg_access(1'b1, 20'h8_0007, 8'hA5, q);
    cfg_access(1'b0, 20'hF_FFFF, 8'h00, q);
    chk("cfg_rd_lane1", 8'hA5, q);
    cfg_access(1'b0, 20'h7_FFFF, 8'h00, q);
    chk("cfg_rd_lane0", 8'h3C, q);
  endtask
  // transport lane l sits at slice l, so input lane 0 (top) comes out in the low slice
  task automatic t_stream();
    logic [127:0] w0, w1;
    w0 = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
    w1 = 128'hFFEE_DDCC_BBAA_9988_7766_5544_3322_1100;
    mgmt_wr(1'b1, OFS_CONTROL, 32'h0000_0001);
    #1 chk("sample_ready_on", 1, sready);
    mgmt_rd(10'h002, got);
    chk("control", 32'h0000_0001, got);
    push(w0, 16'hA150);
    push(w1, 16'h0FF0);
    @(negedge sys_clk);
    chk("sample_ready_full", 0, sready);
    mgmt_rd(OFS_STATUS, got);
    chk("status_full", 32'h0001_0000, got);
    mgmt_rd(OFS_WORD_COUNT, got);
    chk("word_count", 32'h0000_0002, got);
    @(posedge sys_clk);
    tready <= 1'b1;
    @(negedge sys_clk);
    chk("tl_data0", {w0[63:0], w0[127:64]}, tdata);
    chk("tl_ctrl0", 16'h50A1, tctrl);
    @(negedge sys_clk);
    chk("tl_data1", {w1[63:0], w1[127:64]}, tdata);
    chk("tl_ctrl1", 16'hF00F, tctrl);
    @(negedge sys_clk);
    chk("tl_empty", 0, tvalid);
  endtask
  task automatic t_ready();
    @(posedge sys_clk);
    txp <= 2'b10; afep <= 2'b01;
    @(posedge sys_clk);
    #1 chk("tx_ready_early", 2'b00, txr);
    @(posedge sys_clk);
    #1 chk("tx_ready", 2'b10, txr);
    chk("afe_ready", 2'b01, afer);
    mgmt_rd(OFS_STATUS, got);
    chk("status_ready", 32'h0000_0102, got);
  endtask
  // mid-run reset: registers fall back to their reset values, stream gate closes
  task automatic t_reset();
    mgmt_wr(1'b1, OFS_SCRATCH, 32'h0BAD_F00D);
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    #1 chk("reset_sready_again", 0, sready);
    mgmt_rd(OFS_SCRATCH, got);
    chk("scratch_reset", SCRATCH_RESET, got);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    chk("reset_stall", 0, mstall);
    chk("reset_rdata", 0, mrdata);
    chk("reset_sready", 0, sready);
    chk("reset_tvalid", 0, tvalid);
    t_mgmt();
    t_cfg();
    t_stream();
    t_ready();
    t_reset();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
